// [src/ecs_pkg.sv]
// constants shared by the set-context leaf engine: register map, field
// positions, leaf code, page geometry and result codes.
// assumes a 32-bit apb register bus and x86-style flag bit positions.
package ecs_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LEAF = 8'h04;
    localparam logic [7:0] OFS_RCXL = 8'h08;
    localparam logic [7:0] OFS_RCXH = 8'h0c;
    localparam logic [7:0] OFS_RDXL = 8'h10;
    localparam logic [7:0] OFS_RDXH = 8'h14;
    localparam logic [7:0] OFS_MODE = 8'h18;
    localparam logic [7:0] OFS_LIMIT = 8'h1c;
    localparam logic [7:0] OFS_DSBASE = 8'h20;
    localparam logic [7:0] OFS_CBASE = 8'h24;
    localparam logic [7:0] OFS_RAX = 8'h28;
    localparam logic [7:0] OFS_STAT = 8'h2c;
    localparam logic [7:0] OFS_FLAGS = 8'h30;
    localparam logic [7:0] OFS_FEAT = 8'h34;
    localparam logic [7:0] OFS_MSEL = 8'h38;
    localparam logic [7:0] OFS_MCTL = 8'h3c;
    localparam logic [7:0] OFS_CTXL = 8'h40;
    localparam logic [7:0] OFS_CTXH = 8'h44;

    // mode register bits
    localparam int MB_LONG = 0;
    localparam int MB_PROT = 1;
    localparam int MB_SMM = 2;
    localparam int MB_V86 = 3;
    localparam int MB_DSUNUSE = 4;
    localparam int MB_ENABLE = 5;
    localparam int MODE_W = 6;

    // status register bits
    localparam int SB_BUSY = 0;
    localparam int SB_DONE = 1;
    localparam int SB_FLT = 2;
    localparam int SB_PPF = 4;
    localparam int SB_ONRDX = 5;

    // map control fields
    localparam int MC_VALID = 0;
    localparam int MC_TYPE = 8;
    localparam int MC_CREATE = 16;

    // flag bit positions
    localparam int FB_CF = 0;
    localparam int FB_PF = 2;
    localparam int FB_AF = 4;
    localparam int FB_ZF = 6;
    localparam int FB_SF = 7;
    localparam int FB_OF = 11;
    localparam int FLAGS_W = 12;

    localparam logic [31:0] LEAF_SET_CONTEXT = 32'h0000_0002;
    localparam logic [31:0] FEATURE_WORD = 32'h0000_0020;
    localparam int PAGE_SHIFT = 12;
    localparam logic [11:0] PAGE_MASK = 12'hfff;
    localparam logic [2:0] CTX_MASK = 3'h7;
    localparam logic [31:0] RAX_OK = 32'h0000_0000;
    localparam logic [31:0] PAGE_CONFLICT_CODE = 32'h0000_0001;
    // page type code of a control structure page; value is arbitrary
    localparam logic [7:0] CONTROL_STRUCTURE_TYPE = 8'h01;

    // leaf group of another instruction holding a page
    localparam logic [1:0] GRP_EXCL = 2'h0;
    localparam logic [1:0] GRP_ACCEPT = 2'h1;
    localparam logic [1:0] GRP_ADD = 2'h2;
    localparam logic [1:0] GRP_TRACK = 2'h3;

    typedef enum logic [1:0] {
        FLT_NONE = 2'h0,
        FLT_GP = 2'h1,
        FLT_PF = 2'h2,
        FLT_UD = 2'h3
    } ecs_fault_t;
endpackage

// [src/ecs_set_context.sv]
// set-context leaf engine: apb registers, operand checks, context read
// port and a small page cache map with per-page context fields.
// assumes memory and concurrency inputs come from logic on pclk.
`timescale 1ns/10ps

module ecs_set_context #(
    parameter int NPAGES = 4,
    parameter int IW = (NPAGES > 1) ? $clog2(NPAGES) : 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [63:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_fault,
    input wire logic other_busy,
    input wire logic [1:0] other_group,
    input wire logic [IW-1:0] other_page
);
    typedef enum logic [1:0] {S_IDLE, S_CHK, S_RD} ecs_state_t;

    localparam logic [63:0] SPAN = 64'(NPAGES) << ecs_pkg::PAGE_SHIFT;

    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [31:0] leaf_q, leaf_d, limit_q, limit_d, dsbase_q, dsbase_d;
    logic [31:0] cbase_q, cbase_d;
    logic [63:0] rcx_q, rcx_d, rdx_q, rdx_d;
    logic [ecs_pkg::MODE_W-1:0] mode_q, mode_d;
    logic [IW-1:0] msel_q, msel_d;
    ecs_state_t st_q, st_d;
    ecs_pkg::ecs_fault_t flt_q, flt_d;
    logic done_q, done_d, ppf_q, ppf_d, onrdx_q, onrdx_d;
    logic [31:0] rax_q, rax_d;
    logic [ecs_pkg::FLAGS_W-1:0] flags_q, flags_d;
    logic [IW-1:0] tidx_q, tidx_d;
    logic mreq_q, mreq_d;
    logic [63:0] maddr_q, maddr_d;
    logic vld_q [NPAGES];
    logic vld_d [NPAGES];
    logic [7:0] typ_q [NPAGES];
    logic [7:0] typ_d [NPAGES];
    logic [63:0] ctx_q [NPAGES];
    logic [63:0] ctx_d [NPAGES];
    logic acc, wr, go, idle, p64;
    logic avail, segbad, rcx_mis, rcx_out, rdx_mis, conflict;
    logic [63:0] rcx_l, rdx_l, cbase64;

    // address helpers; noncanon, over_limit and linear serve both operands, page_index the page operand only
    function automatic logic noncanon(input logic [63:0] a);
        return !((&a[63:47]) || !(|a[63:47]));
    endfunction

    function automatic logic over_limit(input logic [63:0] a, input logic [31:0] lim);
        return a[31:0] > lim;
    endfunction

    function automatic logic [63:0] linear(input logic [63:0] off, input logic long_m,
                                           input logic [31:0] base);
        logic [31:0] sum;
        sum = off[31:0] + base;
        return long_m ? off : {32'h0000_0000, sum};
    endfunction

    function automatic logic [IW-1:0] page_index(input logic [63:0] a, input logic [63:0] b);
        logic [63:0] off;
        off = a - b;
        return off[ecs_pkg::PAGE_SHIFT +: IW];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a <= ecs_pkg::OFS_CTXH && a[1:0] == 2'h0;
    endfunction

    // bus qualifiers; a transfer completes when pready_q is seen in access
    assign acc = psel && penable;
    assign wr = acc && pready_q && pwrite;
    assign idle = st_q == S_IDLE;
    assign go = wr && paddr == ecs_pkg::OFS_CTRL && pwdata[0] && idle;
    assign p64 = mode_q[ecs_pkg::MB_LONG];
    assign cbase64 = {32'h0000_0000, cbase_q};

    // linear operands always from ds, no override path
    assign rcx_l = linear(rcx_q, p64, dsbase_q);
    assign rdx_l = linear(rdx_q, p64, dsbase_q);

    // check terms in priority order
    assign avail = mode_q[ecs_pkg::MB_ENABLE] && mode_q[ecs_pkg::MB_PROT] &&
                   !mode_q[ecs_pkg::MB_SMM] && !mode_q[ecs_pkg::MB_V86] &&
                   leaf_q == ecs_pkg::LEAF_SET_CONTEXT;
    assign segbad = (mode_q[ecs_pkg::MB_PROT] && mode_q[ecs_pkg::MB_DSUNUSE]) ||
                    (!p64 && (over_limit(rcx_q, limit_q) || over_limit(rdx_q, limit_q))) ||
                    (p64 && (noncanon(rcx_l) || noncanon(rdx_l)));
    assign rcx_mis = (rcx_l[11:0] & ecs_pkg::PAGE_MASK) != 12'h000;
    assign rcx_out = rcx_l < cbase64 || (rcx_l - cbase64) >= SPAN;
    assign rdx_mis = (rdx_l[2:0] & ecs_pkg::CTX_MASK) != 3'h0;
    // only an exclusive modifier of the same page conflicts
    assign conflict = other_busy && other_group == ecs_pkg::GRP_EXCL &&
                      other_page == tidx_q;

    // apb slave: one wait state, read data and error in the ready cycle
    always_comb begin
        pready_d = acc && !pready_q;
        pslverr_d = acc && !pready_q && !mapped(paddr);
        prdata_d = 32'h0000_0000;
        leaf_d = leaf_q;
        rcx_d = rcx_q;
        rdx_d = rdx_q;
        mode_d = mode_q;
        limit_d = limit_q;
        dsbase_d = dsbase_q;
        cbase_d = cbase_q;
        msel_d = msel_q;
        if (acc && !pready_q && !pwrite) begin
            case (paddr)
                ecs_pkg::OFS_LEAF: prdata_d = leaf_q;
                ecs_pkg::OFS_RCXL: prdata_d = rcx_q[31:0];
                ecs_pkg::OFS_RCXH: prdata_d = rcx_q[63:32];
                ecs_pkg::OFS_RDXL: prdata_d = rdx_q[31:0];
                ecs_pkg::OFS_RDXH: prdata_d = rdx_q[63:32];
                ecs_pkg::OFS_MODE: prdata_d[ecs_pkg::MODE_W-1:0] = mode_q;
                ecs_pkg::OFS_LIMIT: prdata_d = limit_q;
                ecs_pkg::OFS_DSBASE: prdata_d = dsbase_q;
                ecs_pkg::OFS_CBASE: prdata_d = cbase_q;
                ecs_pkg::OFS_RAX: prdata_d = rax_q;
                ecs_pkg::OFS_STAT: begin
                    prdata_d[ecs_pkg::SB_BUSY] = !idle;
                    prdata_d[ecs_pkg::SB_DONE] = done_q;
                    prdata_d[ecs_pkg::SB_FLT +: 2] = flt_q;
                    prdata_d[ecs_pkg::SB_PPF] = ppf_q;
                    prdata_d[ecs_pkg::SB_ONRDX] = onrdx_q;
                end
                ecs_pkg::OFS_FLAGS: prdata_d[ecs_pkg::FLAGS_W-1:0] = flags_q;
                ecs_pkg::OFS_FEAT: prdata_d = ecs_pkg::FEATURE_WORD;
                ecs_pkg::OFS_MSEL: prdata_d[IW-1:0] = msel_q;
                ecs_pkg::OFS_MCTL: begin
                    prdata_d[ecs_pkg::MC_VALID] = vld_q[msel_q];
                    prdata_d[ecs_pkg::MC_TYPE +: 8] = typ_q[msel_q];
                end
                ecs_pkg::OFS_CTXL: prdata_d = ctx_q[msel_q][31:0];
                ecs_pkg::OFS_CTXH: prdata_d = ctx_q[msel_q][63:32];
                default: prdata_d = 32'h0000_0000;
            endcase
        end
        // operand writes land only while idle so a running check stays coherent
        if (wr && idle) begin
            case (paddr)
                ecs_pkg::OFS_LEAF: leaf_d = pwdata;
                ecs_pkg::OFS_RCXL: rcx_d[31:0] = pwdata;
                ecs_pkg::OFS_RCXH: rcx_d[63:32] = pwdata;
                ecs_pkg::OFS_RDXL: rdx_d[31:0] = pwdata;
                ecs_pkg::OFS_RDXH: rdx_d[63:32] = pwdata;
                ecs_pkg::OFS_MODE: mode_d = pwdata[ecs_pkg::MODE_W-1:0];
                ecs_pkg::OFS_LIMIT: limit_d = pwdata;
                ecs_pkg::OFS_DSBASE: dsbase_d = pwdata;
                ecs_pkg::OFS_CBASE: cbase_d = pwdata;
                ecs_pkg::OFS_MSEL: msel_d = pwdata[IW-1:0];
                default: msel_d = msel_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            leaf_q <= 32'h0000_0000;
            rcx_q <= 64'h0;
            rdx_q <= 64'h0;
            mode_q <= '0;
            limit_q <= 32'h0000_0000;
            dsbase_q <= 32'h0000_0000;
            cbase_q <= 32'h0000_0000;
            msel_q <= '0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            leaf_q <= leaf_d;
            rcx_q <= rcx_d;
            rdx_q <= rdx_d;
            mode_q <= mode_d;
            limit_q <= limit_d;
            dsbase_q <= dsbase_d;
            cbase_q <= cbase_d;
            msel_q <= msel_d;
        end
    end

    // engine: checks in one cycle, then waits for the context read
    always_comb begin
        st_d = st_q;
        flt_d = flt_q;
        done_d = done_q;
        ppf_d = ppf_q;
        onrdx_d = onrdx_q;
        rax_d = rax_q;
        flags_d = flags_q;
        tidx_d = tidx_q;
        mreq_d = mreq_q;
        maddr_d = maddr_q;
        vld_d = vld_q;
        typ_d = typ_q;
        ctx_d = ctx_q;
        if (wr && idle && paddr == ecs_pkg::OFS_FLAGS) begin
            flags_d = pwdata[ecs_pkg::FLAGS_W-1:0];
        end
        if (wr && idle && paddr == ecs_pkg::OFS_MCTL) begin
            vld_d[msel_q] = pwdata[ecs_pkg::MC_VALID];
            typ_d[msel_q] = pwdata[ecs_pkg::MC_TYPE +: 8];
            if (pwdata[ecs_pkg::MC_CREATE]) begin
                // default context is the page's own address
                ctx_d[msel_q] = cbase64 + (64'(msel_q) << ecs_pkg::PAGE_SHIFT);
            end
        end
        case (st_q)
            S_IDLE: begin
                if (go) begin
                    st_d = S_CHK;
                    flt_d = ecs_pkg::FLT_NONE;
                    done_d = 1'b0;
                    ppf_d = 1'b0;
                    onrdx_d = 1'b0;
                end
            end
            S_CHK: begin
                // faults only touch status; rax, flags and map stay put
                st_d = S_IDLE;
                done_d = 1'b1;
                if (!avail) begin
                    flt_d = ecs_pkg::FLT_UD;
                end else if (segbad) begin
                    flt_d = ecs_pkg::FLT_GP;
                end else if (rcx_mis) begin
                    flt_d = ecs_pkg::FLT_GP;
                end else if (rcx_out) begin
                    flt_d = ecs_pkg::FLT_PF;
                    ppf_d = 1'b1;
                end else if (rdx_mis) begin
                    flt_d = ecs_pkg::FLT_GP;
                end else begin
                    // target index only moves once the page is known in range
                    tidx_d = page_index(rcx_l, cbase64);
                    st_d = S_RD;
                    done_d = 1'b0;
                    mreq_d = 1'b1;
                    maddr_d = rdx_l;
                end
            end
            S_RD: begin
                if (mem_ack) begin
                    mreq_d = 1'b0;
                    st_d = S_IDLE;
                    done_d = 1'b1;
                    if (mem_fault) begin
                        flt_d = ecs_pkg::FLT_PF;
                        onrdx_d = 1'b1;
                    end else if (conflict) begin
                        rax_d = ecs_pkg::PAGE_CONFLICT_CODE;
                        flags_d[ecs_pkg::FB_ZF] = 1'b1;
                        flags_d[ecs_pkg::FB_CF] = 1'b0;
                        flags_d[ecs_pkg::FB_PF] = 1'b0;
                        flags_d[ecs_pkg::FB_AF] = 1'b0;
                        flags_d[ecs_pkg::FB_OF] = 1'b0;
                        flags_d[ecs_pkg::FB_SF] = 1'b0;
                    end else if (!vld_q[tidx_q]) begin
                        flt_d = ecs_pkg::FLT_PF;
                        ppf_d = 1'b1;
                    end else if (typ_q[tidx_q] != ecs_pkg::CONTROL_STRUCTURE_TYPE) begin
                        flt_d = ecs_pkg::FLT_PF;
                        ppf_d = 1'b1;
                    end else begin
                        ctx_d[tidx_q] = mem_rdata;
                        rax_d = ecs_pkg::RAX_OK;
                        flags_d[ecs_pkg::FB_ZF] = 1'b0;
                        flags_d[ecs_pkg::FB_CF] = 1'b0;
                        flags_d[ecs_pkg::FB_PF] = 1'b0;
                        flags_d[ecs_pkg::FB_AF] = 1'b0;
                        flags_d[ecs_pkg::FB_OF] = 1'b0;
                        flags_d[ecs_pkg::FB_SF] = 1'b0;
                    end
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            flt_q <= ecs_pkg::FLT_NONE;
            done_q <= 1'b0;
            ppf_q <= 1'b0;
            onrdx_q <= 1'b0;
            rax_q <= 32'h0000_0000;
            flags_q <= '0;
            tidx_q <= '0;
            mreq_q <= 1'b0;
            maddr_q <= 64'h0;
            for (int i = 0; i < NPAGES; i++) begin
                vld_q[i] <= 1'b0;
                typ_q[i] <= 8'h00;
                ctx_q[i] <= 64'h0;
            end
        end else begin
            st_q <= st_d;
            flt_q <= flt_d;
            done_q <= done_d;
            ppf_q <= ppf_d;
            onrdx_q <= onrdx_d;
            rax_q <= rax_d;
            flags_q <= flags_d;
            tidx_q <= tidx_d;
            mreq_q <= mreq_d;
            maddr_q <= maddr_d;
            vld_q <= vld_d;
            typ_q <= typ_d;
            ctx_q <= ctx_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign mem_req = mreq_q;
    assign mem_addr = maddr_q;

    // checks on the engine's own outputs
    chk_rcx_align: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_CHK && avail && !segbad && rcx_mis |=> flt_q == ecs_pkg::FLT_GP && !ppf_q)
        else $error("misaligned page operand not general protection");
    chk_cache_miss: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_CHK && avail && !segbad && !rcx_mis && rcx_out
        |=> flt_q == ecs_pkg::FLT_PF && ppf_q && !onrdx_q)
        else $error("page outside cache not faulted with flag");
    chk_rdx_align: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_CHK && avail && !segbad && !rcx_mis && !rcx_out && rdx_mis
        |=> flt_q == ecs_pkg::FLT_GP && !mreq_q)
        else $error("misaligned context operand not general protection");
    chk_read_first: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_CHK && st_d == S_RD |=> mreq_q && maddr_q == $past(rdx_l) ##1 !done_q)
        else $error("context read not issued before completion");
    chk_conflict_path: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_RD && mem_ack && !mem_fault && conflict
        |=> rax_q == ecs_pkg::PAGE_CONFLICT_CODE && flags_q[ecs_pkg::FB_ZF] &&
            !flags_q[ecs_pkg::FB_CF] && ctx_q[tidx_q] == $past(ctx_q[tidx_q]))
        else $error("conflict completion wrong");
    chk_shared_groups: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_RD && mem_ack && !mem_fault && other_group != ecs_pkg::GRP_EXCL
        |=> rax_q != ecs_pkg::PAGE_CONFLICT_CODE || flt_q != ecs_pkg::FLT_NONE ||
            $stable(rax_q))
        else $error("shared group reported as conflict");
    chk_success_write: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_RD && mem_ack && !mem_fault && !conflict && vld_q[tidx_q] &&
        typ_q[tidx_q] == ecs_pkg::CONTROL_STRUCTURE_TYPE
        |=> ctx_q[tidx_q] == $past(mem_rdata) && rax_q == ecs_pkg::RAX_OK &&
            !flags_q[ecs_pkg::FB_ZF] && !flags_q[ecs_pkg::FB_SF] && done_q)
        else $error("successful update not reflected");
    chk_fault_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == S_CHK || st_q == S_RD) && flt_d != ecs_pkg::FLT_NONE
        |=> $stable(rax_q) && $stable(flags_q) && ctx_q[tidx_q] == $past(ctx_q[tidx_q]))
        else $error("fault altered architectural state");
    chk_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_CHK && (mode_q[ecs_pkg::MB_SMM] || mode_q[ecs_pkg::MB_V86])
        |=> flt_q == ecs_pkg::FLT_UD && done_q && !mreq_q)
        else $error("leaf ran in a forbidden mode");
endmodule

// [bench/ecs_mem_model.sv]
// memory partner answering the context read port of the leaf engine.
// assumes one read at a time, all signals on pclk.
`timescale 1ns/10ps
module ecs_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic fault_on,
    input wire logic slow,
    output logic mem_ack,
    output logic [63:0] mem_rdata,
    output logic mem_fault
);
    logic [3:0] cnt;
    logic sent;
    // one answer per request, prompt or after six waits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            sent <= 1'b0;
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            mem_rdata <= 64'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_fault <= 1'b0;
            mem_rdata <= ~mem_rdata; // no stale data between answers
            if (!mem_req) begin
                cnt <= 4'h0;
                sent <= 1'b0;
            end else if (!sent && cnt == (slow ? 4'h6 : 4'h0)) begin
                mem_ack <= 1'b1;
                sent <= 1'b1;
                mem_fault <= fault_on;
                mem_rdata <= {~mem_addr[31:0], mem_addr[31:0] ^ 32'h0f0f_0f0f};
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// [bench/ecs_set_context_tb.sv]
// self-checking bench for the set-context leaf engine over apb.
// assumes the memory partner model and the design package.
`timescale 1ns/10ps
module ecs_set_context_tb;
    localparam logic [31:0] CB = 32'h0010_0000;
    localparam logic [63:0] P1 = {32'h0, CB + 32'h1000};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, fault_on = 1'b0, other_busy = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, rng = 32'h930c4964, rax_e = 32'h0;
    logic pready, pslverr, mem_req, mem_ack, mem_fault;
    logic [1:0] other_group = 2'h0, other_page = 2'h0;
    logic [63:0] mem_addr, mem_rdata, ctx_e;
    logic [32:0] q[$];
    int errors = 0, n_checks = 0, cyc = 0;
    ecs_set_context uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault), .other_busy(other_busy), .other_group(other_group), .other_page(other_page));
    ecs_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_addr(mem_addr),
        .fault_on(fault_on), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_fault(mem_fault));
    always #50 pclk = ~pclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // hang guard, well above the thousand or so cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            tally_and_finish;
        end
    end
    // oldest note against each completed read while notes are queued
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
            n_checks = n_checks + 1;
            if ({pslverr, prdata} !== q[0]) begin
                errors = errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, {pslverr, prdata}, q[0]);
            end
            void'(q.pop_front());
        end
    end
    // apb transfer; request held until pready seen at an edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            errors = errors + 1;
            tally_and_finish;
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task chk(input logic [7:0] a, input logic [31:0] e);
        q.push_back({1'b0, e});
        xfer(1'b0, a, 32'h0);
    endtask
    // kind 0 success, 1 conflict, 2 fault
    task run(input logic [63:0] rcx, input logic [31:0] off, input logic [31:0] mode, input logic [31:0] st,
            input int kind);
        logic [63:0] rdx;
        int n;
        rng = xs(rng);
        rdx = {32'h0, rng[31:3], 3'b000} + 64'(off);
        slow <= rng[3];
        wr(ecs_pkg::OFS_RCXL, rcx[31:0]);
        wr(ecs_pkg::OFS_RCXH, rcx[63:32]);
        wr(ecs_pkg::OFS_RDXL, rdx[31:0]);
        wr(ecs_pkg::OFS_RDXH, rdx[63:32]);
        wr(ecs_pkg::OFS_MODE, mode);
        wr(ecs_pkg::OFS_FLAGS, 32'h0000_0fff);
        wr(ecs_pkg::OFS_CTRL, 32'h1);
        n = 0;
        do begin
            xfer(1'b0, ecs_pkg::OFS_STAT, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 30);
        // a leaf that never completes is a hang, not a slow answer
        if (rd[1] !== 1'b1) begin
            errors = errors + 1;
            tally_and_finish;
        end
        if (kind == 0) ctx_e = {~rdx[31:0], rdx[31:0] ^ 32'h0f0f_0f0f};
        if (kind < 2) rax_e = (kind == 0) ? 32'h0 : 32'h1;
        chk(ecs_pkg::OFS_STAT, st);
        chk(ecs_pkg::OFS_RAX, rax_e);
        chk(ecs_pkg::OFS_FLAGS, kind == 0 ? 32'h72a : kind == 1 ? 32'h76a : 32'hfff);
        chk(ecs_pkg::OFS_CTXL, ctx_e[31:0]);
        chk(ecs_pkg::OFS_CTXH, ctx_e[63:32]);
        $display("test done mode %h stat %h", mode, st);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(ecs_pkg::OFS_FEAT, ecs_pkg::FEATURE_WORD);
        q.push_back({1'b1, 32'h0});
        xfer(1'b0, 8'h48, 32'h0);
        wr(ecs_pkg::OFS_LEAF, ecs_pkg::LEAF_SET_CONTEXT);
        wr(ecs_pkg::OFS_CBASE, CB);
        wr(ecs_pkg::OFS_MSEL, 32'h1);
        wr(ecs_pkg::OFS_MCTL, 32'h1_0101);
        chk(ecs_pkg::OFS_CTXL, CB + 32'h1000);
        ctx_e = P1;
        $display("test done setup and create");
        wr(ecs_pkg::OFS_MSEL, 32'h2);
        wr(ecs_pkg::OFS_MCTL, 32'h0201);
        wr(ecs_pkg::OFS_MSEL, 32'h3);
        wr(ecs_pkg::OFS_MCTL, 32'h0100);
        wr(ecs_pkg::OFS_MSEL, 32'h1);
        run(P1, 0, 32'h23, 32'h2, 0);
        other_page <= 2'h1;
        for (int g = 1; g < 4; g++) begin
            other_busy <= 1'b1;
            other_group <= 2'(g);
            run(P1, 0, 32'h23, 32'h2, 0);
        end
        other_group <= 2'h0;
        run(P1, 0, 32'h23, 32'h2, 1);
        other_busy <= 1'b0;
        run(P1 + 64'h8, 0, 32'h23, 32'h6, 2);
        run({32'h0, CB + 32'h4000}, 0, 32'h23, 32'h1a, 2);
        run(P1, 4, 32'h23, 32'h6, 2);
        fault_on <= 1'b1;
        run(P1, 0, 32'h23, 32'h2a, 2);
        fault_on <= 1'b0;
        run(P1 + 64'h2000, 0, 32'h23, 32'h1a, 2);
        run(P1 + 64'h1000, 0, 32'h23, 32'h1a, 2);
        run(P1, 0, 32'h27, 32'he, 2);
        run(P1, 0, 32'h2b, 32'he, 2);
        run(P1, 0, 32'h21, 32'he, 2);
        // a leaf code other than set-context must not run
        wr(ecs_pkg::OFS_LEAF, 32'h0000_0003);
        run(P1, 0, 32'h23, 32'he, 2);
        wr(ecs_pkg::OFS_LEAF, ecs_pkg::LEAF_SET_CONTEXT);
        run(P1, 0, 32'h33, 32'h6, 2);
        run(P1 | 64'h0001_0000_0000_0000, 0, 32'h23, 32'h6, 2);
        wr(ecs_pkg::OFS_LIMIT, 32'h0000_ffff);
        run(P1, 0, 32'h22, 32'h6, 2);
        tally_and_finish;
    end
endmodule
